// file: verilog/ebt_pkg.sv
// ebt_pkg: register offsets, field positions, reset values and mode codes
// for the 8-bit timer with two capture/compare channels.
// assumes an 8-bit register port with byte offsets as addresses.
package ebt_pkg;
	// register offsets
	localparam logic [7:0] CHAN0_COMPARE_VALUE_A = 8'hCD;
	localparam logic [7:0] CHAN1_CONTROL_A = 8'hCE;
	localparam logic [7:0] CHAN1_COMPARE_VALUE_A = 8'hCF;
	localparam logic [7:0] TIMER_FLAG_REG = 8'hD8;
	localparam logic [7:0] COUNTER_VALUE_B = 8'hEA;
	localparam logic [7:0] TIMER_CONTROL_B = 8'hEB;
	localparam logic [7:0] CHAN0_CONTROL_B = 8'hEC;

	// timer control fields
	localparam int TICK_SPEED_LSB = 5;
	localparam int TICK_SPEED_MSB = 7;
	localparam int RUN_BIT = 4;
	localparam int WRAP_IRQ_MASK_BIT = 3;
	localparam int COUNT_CLEAR_BIT = 2;
	localparam int COUNT_MODE_LSB = 0;
	localparam int COUNT_MODE_MSB = 1;

	// channel control fields
	localparam int CHAN_IRQ_MASK_BIT = 6;
	localparam int OUT_ACTION_LSB = 3;
	localparam int OUT_ACTION_MSB = 5;
	localparam int CHAN_MODE_BIT = 2;
	localparam int EDGE_SEL_LSB = 0;
	localparam int EDGE_SEL_MSB = 1;

	// pending flag positions
	localparam int WRAP_PENDING_BIT = 3;
	localparam int CHAN0_PENDING_BIT = 4;
	localparam int CHAN1_PENDING_BIT = 5;

	// reset values
	localparam logic [7:0] VALUE_RESET = 8'h00;
	localparam logic [2:0] TICK_SPEED_RESET = 3'h0;
	localparam logic RUN_RESET = 1'b0;
	localparam logic WRAP_IRQ_MASK_RESET = 1'b1;
	localparam logic [1:0] COUNT_MODE_RESET = 2'h0;
	localparam logic CHAN_IRQ_MASK_RESET = 1'b1;
	localparam logic [2:0] OUT_ACTION_RESET = 3'h0;
	localparam logic CHAN_MODE_RESET = 1'b0;
	localparam logic [1:0] EDGE_SEL_RESET = 2'h0;

	// counting modes
	localparam logic [1:0] MODE_FREE = 2'h0;
	localparam logic [1:0] MODE_DOWN = 2'h1;
	localparam logic [1:0] MODE_MODULO = 2'h2;
	localparam logic [1:0] MODE_UPDOWN = 2'h3;

	// capture edge selections
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// compare output actions
	localparam logic [2:0] ACT_SET = 3'h0;
	localparam logic [2:0] ACT_CLEAR = 3'h1;
	localparam logic [2:0] ACT_TOGGLE = 3'h2;
	localparam logic [2:0] ACT_SET_UP = 3'h3;
	localparam logic [2:0] ACT_CLEAR_UP = 3'h4;
	localparam logic [2:0] ACT_SET_MATCH = 3'h5;
	localparam logic [2:0] ACT_CLEAR_MATCH = 3'h6;
endpackage

// file: verilog/ebt_timer.sv
// ebt_timer: 8-bit timer/counter with prescaler, four counting modes and two
// capture/compare channels, reached over a plain byte register port.
// assumes i_tick is a one-cycle tick enable on i_clk; capture pins are async.
//
// Contract
// (RULE1) prescaler divides the tick by 1 to 128, chosen by a 3-bit field
// (RULE2) counter advances on prescaled ticks only while run is set, else holds
// (RULE3) writing one to clear zeroes the counter; clear bit reads zero
// (RULE4) read-only 8-bit counter register shows live count, resets to zero
// (RULE5) mode 00 counts 0 to 255 and wraps, forever
// (RULE6) mode 01 loads channel 0 value and counts down once to zero
// (RULE7) mode 10 counts 0 to channel 0 value then restarts at zero
// (RULE8) mode 11 counts up to channel 0 value then down to zero, forever
// (RULE9) per-channel interrupt mask bit 6, resets to one; overflow mask resets one
// (RULE10) channel mode bit: zero capture, one compare; resets to capture
// (RULE11) edge field selects none, rising, falling or both input edges
// (RULE12) compare action fires when counter equals the channel's own value
// (RULE13) action 000 sets, 001 clears, 010 toggles on match; 111 unused
// (RULE14) action 011 sets on up match, clears at zero or on down match
// (RULE15) action 100 clears on up match, sets at zero or on down match
// (RULE16) channel 1 action 101/110 sets/clears on match, reverses at channel 0 value
// (RULE17) channel 0 action 101/110 sets/clears on match, reverses at zero
// (RULE18) each channel has a read/write 8-bit value register resetting to zero
// (RULE19) overflow sets a pending flag; software clears it by writing zero
// (RULE20) each channel compare event pulses its own DMA trigger
// (RULE21) selected capture edge copies counter to value register, sets pending
// (RULE22) wrap or terminal count signals overflow; interrupt raised when masked in
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
module ebt_timer (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_tick,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [1:0] i_cap_in,
	output logic [7:0] o_rdata,
	output logic [1:0] o_chan_out,
	output logic [1:0] o_dma_trig,
	output logic [1:0] o_chan_irq,
	output logic o_wrap_irq
);
	// control and value registers
	logic [2:0] tick_speed_q;
	logic run_q;
	logic wrap_irq_mask_q;
	logic [1:0] count_mode_q;
	logic [7:0] count_value_q;
	logic [7:0] count_value_d;
	logic dir_down_q;
	logic dir_down_d;
	logic down_done_q;
	logic down_done_d;
	logic [6:0] presc_q;
	logic [7:0] chan_value_q [2];
	logic [1:0] chan_irq_mask_q;
	logic [2:0] out_action_q [2];
	logic [1:0] chan_mode_q;
	logic [1:0] edge_sel_q [2];
	logic [1:0] chan_pending_q;
	logic wrap_pending_q;
	logic [1:0] sync1_q;
	logic [1:0] sync2_q;
	logic [1:0] sync3_q;
	logic [1:0] chan_out_q;
	logic [1:0] dma_trig_q;
	logic [1:0] chan_irq_q;
	logic wrap_irq_q;
	logic [7:0] rdata_q;

	// register port decode
	wire wr_cc0 = i_wr && (i_addr == ebt_pkg::CHAN0_COMPARE_VALUE_A);
	wire wr_ctl1 = i_wr && (i_addr == ebt_pkg::CHAN1_CONTROL_A);
	wire wr_cc1 = i_wr && (i_addr == ebt_pkg::CHAN1_COMPARE_VALUE_A);
	wire wr_flag = i_wr && (i_addr == ebt_pkg::TIMER_FLAG_REG);
	wire wr_tctl = i_wr && (i_addr == ebt_pkg::TIMER_CONTROL_B);
	wire wr_ctl0 = i_wr && (i_addr == ebt_pkg::CHAN0_CONTROL_B);
	wire [1:0] wr_ctl = {wr_ctl1, wr_ctl0};
	wire [1:0] wr_cc = {wr_cc1, wr_cc0};

	// new control fields carried by a timer control write
	wire [1:0] new_mode = i_wdata[ebt_pkg::COUNT_MODE_MSB:ebt_pkg::COUNT_MODE_LSB];
	wire new_run = i_wdata[ebt_pkg::RUN_BIT];
	// (RULE3) clear on write one
	wire clear_wr = wr_tctl && i_wdata[ebt_pkg::COUNT_CLEAR_BIT];
	// (RULE6) reload on down start
	wire load_down = wr_tctl && new_run && (new_mode == ebt_pkg::MODE_DOWN);

	// (RULE1) prescaler tap: low tick_speed bits of the divider all ones
	wire [6:0] presc_mask = 7'h7F >> (3'h7 - tick_speed_q);
	wire presc_hit = i_tick && ((presc_q & presc_mask) == presc_mask);
	// (RULE2) count only while running
	wire step = run_q && presc_hit && !clear_wr && !load_down;

	wire [7:0] cc0 = chan_value_q[0];
	wire updown = (count_mode_q == ebt_pkg::MODE_UPDOWN);

	// prescaler divider, restarted by a counter clear
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || clear_wr) begin
			presc_q <= 7'h00;
		end else if (i_tick) begin
			presc_q <= presc_q + 7'h01;
		end
	end

	// next counter value per counting mode
	logic wrap_ev;
	logic moved;
	logic step_up;
	always_comb begin
		count_value_d = count_value_q;
		dir_down_d = dir_down_q;
		down_done_d = down_done_q;
		wrap_ev = 1'b0;
		moved = 1'b0;
		step_up = 1'b1;
		if (clear_wr) begin
			count_value_d = ebt_pkg::VALUE_RESET;
			dir_down_d = 1'b0;
			down_done_d = 1'b0;
		end else if (load_down) begin
			count_value_d = cc0;
			down_done_d = 1'b0;
		end else if (step) begin
			unique case (count_mode_q)
				// (RULE5) free running wrap
				ebt_pkg::MODE_FREE: begin
					count_value_d = count_value_q + 8'h01;
					wrap_ev = (count_value_q == 8'hFF);
					moved = 1'b1;
				end
				// (RULE6) single count down
				ebt_pkg::MODE_DOWN: begin
					step_up = 1'b0;
					if (!down_done_q) begin
						moved = 1'b1;
						if (count_value_q <= 8'h01) begin
							count_value_d = 8'h00;
							down_done_d = 1'b1;
							// (RULE22) terminal count of down mode
							wrap_ev = 1'b1;
						end else begin
							count_value_d = count_value_q - 8'h01;
						end
					end
				end
				// (RULE7) modulo restart
				ebt_pkg::MODE_MODULO: begin
					moved = 1'b1;
					if (count_value_q >= cc0) begin
						count_value_d = 8'h00;
						wrap_ev = 1'b1;
					end else begin
						count_value_d = count_value_q + 8'h01;
					end
				end
				// (RULE8) up then down
				ebt_pkg::MODE_UPDOWN: begin
					moved = 1'b1;
					if (!dir_down_q && count_value_q < cc0) begin
						count_value_d = count_value_q + 8'h01;
					end else if (count_value_q <= 8'h01) begin
						step_up = 1'b0;
						count_value_d = 8'h00;
						dir_down_d = 1'b0;
						wrap_ev = 1'b1;
					end else begin
						step_up = 1'b0;
						count_value_d = count_value_q - 8'h01;
						dir_down_d = 1'b1;
					end
				end
			endcase
		end
	end

	// (RULE4) live counter register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			count_value_q <= ebt_pkg::VALUE_RESET;
			dir_down_q <= 1'b0;
			down_done_q <= 1'b0;
		end else begin
			count_value_q <= count_value_d;
			dir_down_q <= dir_down_d;
			down_done_q <= down_done_d;
		end
	end

	// timer control register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			tick_speed_q <= ebt_pkg::TICK_SPEED_RESET;
			run_q <= ebt_pkg::RUN_RESET;
			wrap_irq_mask_q <= ebt_pkg::WRAP_IRQ_MASK_RESET;
			count_mode_q <= ebt_pkg::COUNT_MODE_RESET;
		end else if (wr_tctl) begin
			tick_speed_q <= i_wdata[ebt_pkg::TICK_SPEED_MSB:ebt_pkg::TICK_SPEED_LSB];
			run_q <= new_run;
			wrap_irq_mask_q <= i_wdata[ebt_pkg::WRAP_IRQ_MASK_BIT];
			count_mode_q <= new_mode;
		end
	end

	// events seen on the counter's step
	wire zero_ev = moved && (count_value_d == 8'h00);
	wire top_ev = moved && (count_value_d == cc0);
	logic [1:0] match_ev;
	logic [1:0] cap_ev;
	logic [1:0] chan_pin;

	// (RULE19) overflow pending flag, hardware set wins over a write of zero
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wrap_pending_q <= 1'b0;
		end else begin
			wrap_pending_q <= wrap_ev ||
				(wrap_pending_q && !(wr_flag && !i_wdata[ebt_pkg::WRAP_PENDING_BIT]));
		end
	end

	// (RULE22) overflow interrupt gated by its mask
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wrap_irq_q <= 1'b0;
		end else begin
			wrap_irq_q <= wrap_pending_q && wrap_irq_mask_q;
		end
	end

	// capture pins pass two flip-flops, a third holds the old level
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
			sync3_q <= 2'h0;
		end else begin
			sync1_q <= i_cap_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// per-channel capture/compare logic
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			wire rise = sync2_q[ch] && !sync3_q[ch];
			wire fall = !sync2_q[ch] && sync3_q[ch];
			// (RULE11) edge selection
			wire edge_hit = (edge_sel_q[ch] == ebt_pkg::EDGE_RISE && rise) ||
				(edge_sel_q[ch] == ebt_pkg::EDGE_FALL && fall) ||
				(edge_sel_q[ch] == ebt_pkg::EDGE_BOTH && (rise || fall));
			// (RULE10) capture when mode bit is zero
			assign cap_ev[ch] = !chan_mode_q[ch] && edge_hit;
			// (RULE12) match on own value
			assign match_ev[ch] = chan_mode_q[ch] && moved &&
				(count_value_d == chan_value_q[ch]);
			// second event: zero for channel 0, channel 0 value for channel 1
			wire alt_ev = (ch == 0) ? zero_ev : top_ev;
			wire flag_clr = wr_flag && !i_wdata[ebt_pkg::CHAN0_PENDING_BIT + ch];

			// (RULE9) channel control register, mask resets to one
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					chan_irq_mask_q[ch] <= ebt_pkg::CHAN_IRQ_MASK_RESET;
					out_action_q[ch] <= ebt_pkg::OUT_ACTION_RESET;
					chan_mode_q[ch] <= ebt_pkg::CHAN_MODE_RESET;
					edge_sel_q[ch] <= ebt_pkg::EDGE_SEL_RESET;
				end else if (wr_ctl[ch]) begin
					chan_irq_mask_q[ch] <= i_wdata[ebt_pkg::CHAN_IRQ_MASK_BIT];
					out_action_q[ch] <= i_wdata[ebt_pkg::OUT_ACTION_MSB:ebt_pkg::OUT_ACTION_LSB];
					chan_mode_q[ch] <= i_wdata[ebt_pkg::CHAN_MODE_BIT];
					edge_sel_q[ch] <= i_wdata[ebt_pkg::EDGE_SEL_MSB:ebt_pkg::EDGE_SEL_LSB];
				end
			end

			// (RULE18) value register; (RULE21) capture wins over a write
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					chan_value_q[ch] <= ebt_pkg::VALUE_RESET;
				end else if (cap_ev[ch]) begin
					chan_value_q[ch] <= count_value_q;
				end else if (wr_cc[ch]) begin
					chan_value_q[ch] <= i_wdata;
				end
			end

			// (RULE21) pending flag set by capture or match, set beats clear
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					chan_pending_q[ch] <= 1'b0;
				end else begin
					chan_pending_q[ch] <= cap_ev[ch] || match_ev[ch] ||
						(chan_pending_q[ch] && !flag_clr);
				end
			end

			// channel interrupt gated by its mask
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					chan_irq_q[ch] <= 1'b0;
				end else begin
					chan_irq_q[ch] <= chan_pending_q[ch] && chan_irq_mask_q[ch];
				end
			end

			// (RULE20) one-cycle DMA trigger on compare
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					dma_trig_q[ch] <= 1'b0;
				end else begin
					dma_trig_q[ch] <= match_ev[ch];
				end
			end

			// (RULE13) output actions; match takes priority over the second event
			always_comb begin
				chan_pin[ch] = chan_out_q[ch];
				if (chan_mode_q[ch]) begin
					unique case (out_action_q[ch])
						ebt_pkg::ACT_SET: begin
							if (match_ev[ch]) chan_pin[ch] = 1'b1;
						end
						ebt_pkg::ACT_CLEAR: begin
							if (match_ev[ch]) chan_pin[ch] = 1'b0;
						end
						ebt_pkg::ACT_TOGGLE: begin
							if (match_ev[ch]) chan_pin[ch] = !chan_out_q[ch];
						end
						// (RULE14) set up, clear at zero or down
						ebt_pkg::ACT_SET_UP: begin
							if (match_ev[ch]) chan_pin[ch] = step_up;
							else if (!updown && zero_ev) chan_pin[ch] = 1'b0;
						end
						// (RULE15) clear up, set at zero or down
						ebt_pkg::ACT_CLEAR_UP: begin
							if (match_ev[ch]) chan_pin[ch] = !step_up;
							else if (!updown && zero_ev) chan_pin[ch] = 1'b1;
						end
						// (RULE16) (RULE17) set on match, clear on second event
						ebt_pkg::ACT_SET_MATCH: begin
							if (match_ev[ch]) chan_pin[ch] = 1'b1;
							else if (alt_ev) chan_pin[ch] = 1'b0;
						end
						ebt_pkg::ACT_CLEAR_MATCH: begin
							if (match_ev[ch]) chan_pin[ch] = 1'b0;
							else if (alt_ev) chan_pin[ch] = 1'b1;
						end
						default: begin
							chan_pin[ch] = chan_out_q[ch];
						end
					endcase
				end
			end

			// channel output pin register
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					chan_out_q[ch] <= 1'b0;
				end else begin
					chan_out_q[ch] <= chan_pin[ch];
				end
			end
		end
	endgenerate

	// read multiplexer; unmapped offsets read zero
	wire [7:0] tctl_rd = {tick_speed_q, run_q, wrap_irq_mask_q, 1'b0, count_mode_q};
	wire [7:0] ctl0_rd = {1'b0, chan_irq_mask_q[0], out_action_q[0], chan_mode_q[0],
		edge_sel_q[0]};
	wire [7:0] ctl1_rd = {1'b0, chan_irq_mask_q[1], out_action_q[1], chan_mode_q[1],
		edge_sel_q[1]};
	wire [7:0] flag_rd = {2'h0, chan_pending_q, wrap_pending_q, 3'h0};
	wire [7:0] rd_mux =
		(i_addr == ebt_pkg::CHAN0_COMPARE_VALUE_A) ? chan_value_q[0] :
		(i_addr == ebt_pkg::CHAN1_CONTROL_A) ? ctl1_rd :
		(i_addr == ebt_pkg::CHAN1_COMPARE_VALUE_A) ? chan_value_q[1] :
		(i_addr == ebt_pkg::TIMER_FLAG_REG) ? flag_rd :
		(i_addr == ebt_pkg::COUNTER_VALUE_B) ? count_value_q :
		(i_addr == ebt_pkg::TIMER_CONTROL_B) ? tctl_rd :
		(i_addr == ebt_pkg::CHAN0_CONTROL_B) ? ctl0_rd : 8'h00;

	// read data stands for the one cycle after the read strobe
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rdata_q <= 8'h00;
		end else if (i_rd) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign o_rdata = rdata_q;
	assign o_chan_out = chan_out_q;
	assign o_dma_trig = dma_trig_q;
	assign o_chan_irq = chan_irq_q;
	assign o_wrap_irq = wrap_irq_q;
endmodule // ebt_timer

// file: bench/ebt_timer_asserts.sv
// ebt_timer_asserts: port-level temporal checks for the timer block.
// assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/10ps
module ebt_timer_asserts (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_tick,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [1:0] i_cap_in,
	input wire logic [7:0] o_rdata,
	input wire logic [1:0] o_chan_out,
	input wire logic [1:0] o_dma_trig,
	input wire logic [1:0] o_chan_irq,
	input wire logic o_wrap_irq
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_read_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside its slot");
	a_clear_reads0: assert property (i_rd && i_addr == 8'hEB |=> !o_rdata[2])
		else $error("clear bit read back as one");
	a_clear_zeroes: assert property ((i_wr && i_addr == 8'hEB && i_wdata[2] && !i_wdata[4])
		##2 (i_rd && i_addr == 8'hEA) |=> o_rdata == 8'h00)
		else $error("counter not zero after clear");
	a_ctl_unused: assert property (i_rd && (i_addr == 8'hEC || i_addr == 8'hCE)
		|=> !o_rdata[7])
		else $error("unused control bit read as one");
	a_flag_unused: assert property (i_rd && i_addr == 8'hD8 |=> (o_rdata & 8'hC7) == 8'h00)
		else $error("unused flag bits read as one");
	a_dma_cause: assert property (o_dma_trig != 2'h0 |-> $past(i_tick))
		else $error("dma pulse without a counter step");
	a_out_cause: assert property ($changed(o_chan_out) |-> $past(i_tick))
		else $error("channel output moved without a cause");
	a_wrap_cause: assert property ($rose(o_wrap_irq) |-> $past(i_tick, 2) || $past(i_wr, 2))
		else $error("wrap interrupt without a cause");
endmodule // ebt_timer_asserts

bind ebt_timer ebt_timer_asserts i_ebt_timer_asserts (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_tick(i_tick), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.i_cap_in(i_cap_in), .o_rdata(o_rdata), .o_chan_out(o_chan_out),
	.o_dma_trig(o_dma_trig), .o_chan_irq(o_chan_irq), .o_wrap_irq(o_wrap_irq));

// file: bench/testbench.sv
// testbench: register-level tests of the timer over its byte port.
// assumes read data one cycle after the strobe; tick runs at full rate except in the held-without-tick check.
`timescale 1ns/10ps
module testbench;
	logic i_clk, i_rst_n, i_tick, i_wr, i_rd;
	logic [7:0] i_addr, i_wdata, o_rdata, v, x, e, mx;
	logic [1:0] i_cap_in, o_chan_out, o_dma_trig, o_chan_irq;
	logic o_wrap_irq, dn, lv, hi;
	int fails;
	int tests_run;
	int dma_n;
	int nd;

	ebt_timer i_ebt_timer (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tick(i_tick),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_cap_in(i_cap_in), .o_rdata(o_rdata), .o_chan_out(o_chan_out),
		.o_dma_trig(o_dma_trig), .o_chan_irq(o_chan_irq), .o_wrap_irq(o_wrap_irq));

	// clock generation
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// count channel 1 compare pulses, one per cycle seen high
	always @(posedge i_clk) begin
		if (o_dma_trig[1]) begin
			dma_n <= dma_n + 1;
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp, what);
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// stop a hung run
	initial begin
		repeat (60000) @(posedge i_clk);
		fails++;
		close_out();
	end

	// main sequence
	initial begin
		fails = 0;
		tests_run = 0;
		i_rst_n = 1'b0;
		i_tick = 1'b1;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_cap_in = 2'h0;
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rc(8'hEB, 8'h08, "timer ctl reset");
		rc(8'hEC, 8'h40, "ch0 ctl reset");
		rc(8'hCE, 8'h40, "ch1 ctl reset");
		rc(8'hCD, 8'h00, "ch0 value reset");
		rc(8'hCF, 8'h00, "ch1 value reset");
		rc(8'hD8, 8'h00, "flags reset");
		rc(8'h00, 8'h00, "unmapped");
		wr(8'hEA, 8'h55);
		rc(8'hEA, 8'h00, "counter read only");
		wr(8'hCD, 8'hA5);
		rc(8'hCD, 8'hA5, "ch0 value");
		wr(8'hCF, 8'h5A);
		rc(8'hCF, 8'h5A, "ch1 value");
		wr(8'hCE, 8'hFF);
		rc(8'hCE, 8'h7F, "ch1 ctl");
		wr(8'hEC, 8'hFF);
		rc(8'hEC, 8'h7F, "ch0 ctl");
		wr(8'hEC, 8'h40);
		wr(8'hCE, 8'h40);
		$display("registers done");
		// every divider code over a 128-cycle run window
		for (int d = 0; d < 8; d++) begin
			wr(8'hEB, {d[2:0], 5'h1C});
			repeat (126) @(posedge i_clk);
			wr(8'hEB, 8'h08);
			rd(8'hEA, v);
			e = 8'(128 >> d);
			chk(8'((v + 8'h01 >= e) && (v <= e + 8'h01)), 8'h01, "prescaled count");
		end
		rd(8'hEA, x);
		@(posedge i_clk);
		i_tick <= 1'b0;
		wr(8'hEB, 8'h18);
		repeat (20) @(posedge i_clk);
		rc(8'hEA, x, "held without tick");
		@(posedge i_clk);
		i_tick <= 1'b1;
		wr(8'hEB, 8'h08);
		rd(8'hEA, x);
		repeat (10) @(posedge i_clk);
		rc(8'hEA, x, "held when stopped");
		wr(8'hEB, 8'h0C);
		rc(8'hEA, 8'h00, "cleared");
		rc(8'hEB, 8'h08, "clear reads zero");
		$display("prescaler done");
		// each counting mode with top value 20
		wr(8'hCD, 8'h14);
		for (int m = 0; m < 4; m++) begin
			// a clear beside the down-mode start would zero the reload
			wr(8'hEB, (m == 1) ? 8'h19 : (8'h1C | 8'(m)));
			mx = 8'h00;
			dn = 1'b0;
			x = 8'h00;
			repeat (40) begin
				rd(8'hEA, v);
				if (x == v + 8'h02) dn = 1'b1;
				if (v > mx) mx = v;
				x = v;
			end
			chk(8'(mx > 8'h14), 8'(m == 0), "above top");
			chk(8'(dn), 8'(m[0]), "counting down");
			repeat (300) @(posedge i_clk);
			wr(8'hEB, 8'h08);
			chk(8'(o_wrap_irq), 8'h01, "wrap irq");
			rc(8'hD8, 8'h08, "wrap pending");
			wr(8'hD8, 8'h00);
			repeat (3) @(posedge i_clk);
			chk(8'(o_wrap_irq), 8'h00, "wrap irq cleared");
		end
		wr(8'hEB, 8'h11);
		repeat (40) @(posedge i_clk);
		rc(8'hD8, 8'h08, "masked pending");
		chk(8'(o_wrap_irq), 8'h00, "masked wrap irq");
		wr(8'hD8, 8'h00);
		$display("modes done");
		// channel 1 compare actions in modulo mode
		wr(8'hCF, 8'h0A);
		for (int a = 0; a < 7; a++) begin
			wr(8'hCE, 8'h44 | 8'(a << 3));
			dn = o_chan_out[1];
			nd = dma_n;
			wr(8'hEB, 8'h1A);
			repeat (50 + 3 * a) @(posedge i_clk);
			wr(8'hEB, 8'h0A);
			repeat (4) @(posedge i_clk);
			rd(8'hEA, v);
			chk(8'(v <= 8'h14), 8'h01, "modulo top");
			lv = v >= 8'h0A;
			hi = lv && v < 8'h14;
			e = 8'((a == 0) | (a == 3 & lv) | (a == 4 & !lv) | (a == 5 & hi) | (a == 6 & !hi) |
				(a == 2 & (dn ^ 1'(dma_n - nd))));
			chk(8'(o_chan_out[1]), e, "ch1 output");
			chk(8'(dma_n != nd), 8'h01, "ch1 dma pulses");
		end
		chk(8'(o_chan_irq[1]), 8'h01, "ch1 compare irq");
		wr(8'hD8, 8'h00);
		// channel 0 actions 101/110 in free mode with its value at 0x80
		wr(8'hCD, 8'h80);
		for (int a = 5; a < 7; a++) begin
			wr(8'hEC, 8'h44 | 8'(a << 3));
			wr(8'hEB, 8'h18);
			repeat (300) @(posedge i_clk);
			wr(8'hEB, 8'h08);
			rd(8'hEA, v);
			chk(8'(o_chan_out[0]), 8'((a == 5) ^ (v < 8'h80)), "ch0 output");
		end
		chk(8'(o_chan_irq[0]), 8'h01, "ch0 compare irq");
		wr(8'hEC, 8'h34);
		repeat (2) @(posedge i_clk);
		chk(8'(o_chan_irq[0]), 8'h00, "ch0 masked irq");
		wr(8'hEC, 8'h40);
		// channel 1 actions 011/100 in up/down mode, top 20, match 10
		wr(8'hCD, 8'h14);
		for (int a = 3; a < 5; a++) begin
			wr(8'hCE, 8'h44 | 8'(a << 3));
			wr(8'hEB, 8'h1F);
			repeat (60 + 5 * a) @(posedge i_clk);
			wr(8'hEB, 8'h0B);
			rd(8'hEA, v);
			chk(8'(o_chan_out[1]), 8'((a == 4) ^ (v > 8'h0A)), "ch1 updown out");
		end
		wr(8'hD8, 8'h00);
		$display("compare done");
		// channel 1 capture for every edge selection
		wr(8'hCE, 8'h40);
		wr(8'hEB, 8'h1C);
		wr(8'hEB, 8'h08);
		rd(8'hEA, x);
		for (int c = 0; c < 4; c++) begin
			wr(8'hCE, 8'h40 | 8'(c));
			wr(8'hCF, 8'h00);
			i_cap_in[1] <= 1'b1;
			repeat (6) @(posedge i_clk);
			rc(8'hCF, c[0] ? x : 8'h00, "rise capture");
			wr(8'hCF, 8'h00);
			i_cap_in[1] <= 1'b0;
			repeat (6) @(posedge i_clk);
			rc(8'hCF, c[1] ? x : 8'h00, "fall capture");
			chk(8'(o_chan_irq[1]), 8'(c != 0), "ch1 capture irq");
			wr(8'hD8, 8'h00);
		end
		$display("capture done");
		close_out();
	end
endmodule // testbench
